// ===== core/int_prio_pkg.sv
// package: register map, field layout and constants of the interrupt priority resolver
package int_prio_pkg;

	// ------------------------------------------------------------------
	// register word indices (printed offsets are not multiples of four,
	// so each offset is an index and the byte address is four times it)
	// ------------------------------------------------------------------
	localparam logic [7:0] IDX_PRIO_LOW = 8'ha9;
	localparam logic [7:0] IDX_PRIO_HIGH = 8'hb9;
	localparam logic [7:0] IDX_FLAGS_FIVE = 8'he8;
	localparam logic [7:0] IDX_INT_STATUS = 8'hf0;
	localparam logic [7:0] IDX_INT_MASK = 8'hf1;
	localparam logic [7:0] IDX_SERVICE = 8'hf2;
	localparam logic [7:0] IDX_PENDING_LO = 8'hf3;
	localparam logic [7:0] IDX_PENDING_HI = 8'hf4;

	// ------------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------------
	localparam int NUM_GROUPS = 6;
	localparam int NUM_SOURCES = 18;
	localparam int NUM_FLAGS = 5;
	localparam logic [5:0] PRIO_RESET = 6'h00;
	localparam logic [4:0] FLAGS_RESET = 5'h00;
	localparam int FLAG_WATCHDOG = 4;
	localparam int FLAG_PORT_ONE = 3;
	localparam int FLAG_SERIAL_B_TX = 2;
	localparam int FLAG_SERIAL_A_TX = 1;
	localparam int FLAG_PORT_TWO = 0;
	// interrupt numbers held in cpu_int_flags_five, by flag bit
	localparam int SRC_PORT_TWO = 6;
	localparam int SRC_SERIAL_A_TX = 7;
	localparam int SRC_SERIAL_B_TX = 14;
	localparam int SRC_PORT_ONE = 15;
	localparam int SRC_WATCHDOG = 17;

	// status bits of the block's own event register
	localparam int EV_TAKEN = 0;
	localparam int EV_PREEMPT = 1;
	localparam int EV_RETURN = 2;
	localparam logic [2:0] EV_RESET = 3'h0;

	localparam logic [4:0] NO_SOURCE = 5'h1f;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage

// ===== core/interrupt_priority_resolver.sv
// interrupt priority resolver: level registers, flag register, nesting and bus slave
// ------------------------------------------------------------------
// Overview of operation
// - six groups, levels only from two registers
// - four levels, all groups lowest after reset
// - high register bits 5:0 give upper bit
// - low register bits 5:0 give lower bit
// - in-service level blocks lower or equal requests
// - equal levels resolved by fixed polling order
// - poll order 0,16,8,1,9,2,...,15,17; first wins
// - fixed membership of interrupts in six groups
// - flag five register bit layout, 7:5 unused
// - flags read pending, software writable, reset zero
// ------------------------------------------------------------------
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module interrupt_priority_resolver (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// avalon-mm slave
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// source pulses, same clock
	input wire logic [17:0] src_req_i,
	// cpu handshake
	input wire logic cpu_ack_i,
	input wire logic cpu_reti_i,
	output logic cpu_int_req_o,
	output logic [4:0] cpu_int_num_o,
	// status interrupt
	output logic irq_o
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [5:0] prio_low_q, prio_low_d;
	logic [5:0] prio_high_q, prio_high_d;
	logic [4:0] flags_q, flags_d;
	logic [12:0] pend_other_q, pend_other_d;
	logic [3:0] active_q, active_d;
	logic [2:0] ev_q, ev_d;
	logic [2:0] mask_q, mask_d;
	logic [31:0] rdata_q, rdata_d;
	logic ack_phase_q, ack_phase_d;
	logic req_q, req_d;
	logic [4:0] num_q, num_d;
	logic irq_q, irq_d;
	logic [1:0] lvl_q, lvl_d;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ANSWER = 2'b01
	} bus_state_e;
	bus_state_e bus_q, bus_d;

	logic [17:0] pending;
	logic [11:0] group_level;
	logic win_valid;
	logic [4:0] win_num;
	logic [1:0] win_level;
	logic [1:0] cur_level;
	logic cur_any;
	logic eligible;
	logic [17:0] take;
	logic taken;
	logic returned;

	// ------------------------------------------------------------------
	// number mapping shared by the set and the clear of pending sources
	// ------------------------------------------------------------------
	// flag five bits of a vector indexed by interrupt number
	function automatic logic [4:0] flags_of(input logic [17:0] v);
		logic [4:0] f;
		f = '0;
		f[int_prio_pkg::FLAG_PORT_TWO] = v[int_prio_pkg::SRC_PORT_TWO];
		f[int_prio_pkg::FLAG_SERIAL_A_TX] = v[int_prio_pkg::SRC_SERIAL_A_TX];
		f[int_prio_pkg::FLAG_SERIAL_B_TX] = v[int_prio_pkg::SRC_SERIAL_B_TX];
		f[int_prio_pkg::FLAG_PORT_ONE] = v[int_prio_pkg::SRC_PORT_ONE];
		f[int_prio_pkg::FLAG_WATCHDOG] = v[int_prio_pkg::SRC_WATCHDOG];
		return f;
	endfunction

	// the thirteen other sources, packed low numbers first
	function automatic logic [12:0] others_of(input logic [17:0] v);
		return {v[16], v[13:8], v[5:0]};
	endfunction

	// ------------------------------------------------------------------
	// pending vector and group levels
	// ------------------------------------------------------------------
	// flags five sit at their interrupt numbers, the rest are kept internally
	always_comb begin
		pending = '0;
		pending[5:0] = pend_other_q[5:0];
		pending[13:8] = pend_other_q[11:6];
		pending[16] = pend_other_q[12];
		pending[int_prio_pkg::SRC_PORT_TWO] = flags_q[int_prio_pkg::FLAG_PORT_TWO];
		pending[int_prio_pkg::SRC_SERIAL_A_TX] = flags_q[int_prio_pkg::FLAG_SERIAL_A_TX];
		pending[int_prio_pkg::SRC_SERIAL_B_TX] = flags_q[int_prio_pkg::FLAG_SERIAL_B_TX];
		pending[int_prio_pkg::SRC_PORT_ONE] = flags_q[int_prio_pkg::FLAG_PORT_ONE];
		pending[int_prio_pkg::SRC_WATCHDOG] = flags_q[int_prio_pkg::FLAG_WATCHDOG];
	end

	// level = {upper, lower} per group, taken only from the two registers
	always_comb begin
		group_level = '0;
		for (int g = 0; g < int_prio_pkg::NUM_GROUPS; g++) begin
			group_level[2*g +: 2] = {prio_high_q[g], prio_low_q[g]};
		end
	end

	prio_select u_select (
		.req_i(pending),
		.group_level_i(group_level),
		.valid_o(win_valid),
		.num_o(win_num),
		.level_o(win_level)
	);

	// highest active level; one active bit per level gives nesting
	always_comb begin
		cur_any = |active_q;
		cur_level = 2'h0;
		for (int l = 0; l < 4; l++) begin
			if (active_q[l]) begin
				cur_level = 2'(l);
			end
		end
		eligible = win_valid && (!cur_any || win_level > cur_level);
	end

	// ------------------------------------------------------------------
	// bus slave: one wait cycle, answer on the second edge
	// ------------------------------------------------------------------
	logic [7:0] idx;
	logic wr_hit, rd_hit;
	assign idx = avs_address_i[9:2];
	assign wr_hit = (bus_q == BUS_ANSWER) && avs_write_i && avs_byteenable_i[0];
	assign rd_hit = (bus_q == BUS_ANSWER) && avs_read_i;

	always_comb begin
		bus_d = bus_q;
		rdata_d = rdata_q;
		unique case (bus_q)
			BUS_IDLE: begin
				if (avs_read_i || avs_write_i) begin
					bus_d = BUS_ANSWER;
					rdata_d = int_prio_pkg::UNMAPPED_DATA;
					unique case (idx)
						int_prio_pkg::IDX_PRIO_LOW: rdata_d = {26'h0, prio_low_q};
						int_prio_pkg::IDX_PRIO_HIGH: rdata_d = {26'h0, prio_high_q};
						int_prio_pkg::IDX_FLAGS_FIVE: rdata_d = {27'h0, flags_q};
						int_prio_pkg::IDX_INT_STATUS: rdata_d = {29'h0, ev_q};
						int_prio_pkg::IDX_INT_MASK: rdata_d = {29'h0, mask_q};
						int_prio_pkg::IDX_SERVICE: rdata_d = {23'h0, num_q, active_q};
						int_prio_pkg::IDX_PENDING_LO: rdata_d = {24'h0, pending[7:0]};
						int_prio_pkg::IDX_PENDING_HI: rdata_d = {22'h0, pending[17:8]};
						default: rdata_d = int_prio_pkg::UNMAPPED_DATA;
					endcase
				end
			end
			BUS_ANSWER: bus_d = BUS_IDLE;
			default: bus_d = BUS_IDLE;
		endcase
	end

	// bus state and the registered answer
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_q <= BUS_IDLE;
			rdata_q <= '0;
		end else begin
			bus_q <= bus_d;
			rdata_q <= rdata_d;
		end
	end

	// ------------------------------------------------------------------
	// level and mask registers
	// ------------------------------------------------------------------
	// a write lands only with the low byte enabled
	always_comb begin
		prio_low_d = prio_low_q;
		prio_high_d = prio_high_q;
		mask_d = mask_q;
		if (wr_hit) begin
			unique case (idx)
				int_prio_pkg::IDX_PRIO_LOW: prio_low_d = avs_writedata_i[5:0];
				int_prio_pkg::IDX_PRIO_HIGH: prio_high_d = avs_writedata_i[5:0];
				int_prio_pkg::IDX_INT_MASK: mask_d = avs_writedata_i[2:0];
				default: ;
			endcase
		end
	end

	// all groups start at the lowest level
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prio_low_q <= int_prio_pkg::PRIO_RESET;
			prio_high_q <= int_prio_pkg::PRIO_RESET;
			mask_q <= int_prio_pkg::EV_RESET;
		end else begin
			prio_low_q <= prio_low_d;
			prio_high_q <= prio_high_d;
			mask_q <= mask_d;
		end
	end

	// ------------------------------------------------------------------
	// pending sources
	// ------------------------------------------------------------------
	assign taken = req_q && cpu_ack_i;
	assign take = 18'h1 << num_q;

	// write, then the taken source leaves, then pulses set: a pulse always wins
	always_comb begin
		flags_d = flags_q;
		pend_other_d = pend_other_q;
		if (wr_hit && idx == int_prio_pkg::IDX_FLAGS_FIVE) begin
			flags_d = avs_writedata_i[4:0];
		end
		if (taken) begin
			flags_d = flags_d & ~flags_of(take);
			pend_other_d = pend_other_d & ~others_of(take);
		end
		flags_d = flags_d | flags_of(src_req_i);
		pend_other_d = pend_other_d | others_of(src_req_i);
	end

	// nothing pending after reset
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flags_q <= int_prio_pkg::FLAGS_RESET;
			pend_other_q <= '0;
		end else begin
			flags_q <= flags_d;
			pend_other_q <= pend_other_d;
		end
	end

	// ------------------------------------------------------------------
	// nesting and the vector on offer
	// ------------------------------------------------------------------
	assign returned = cpu_reti_i && cur_any;

	// a return drops its level before a same-cycle take marks its own; the
	// offered level travels with the number since the winner may move on
	always_comb begin
		active_d = active_q;
		ack_phase_d = taken;
		req_d = req_q;
		num_d = num_q;
		lvl_d = lvl_q;
		if (returned) begin
			active_d[cur_level] = 1'b0; // preempted level resumes
		end
		if (taken) begin
			active_d[lvl_q] = 1'b1;
			req_d = 1'b0;
			num_d = int_prio_pkg::NO_SOURCE;
		end else if (!ack_phase_q) begin
			req_d = eligible;
			num_d = eligible ? win_num : int_prio_pkg::NO_SOURCE;
			lvl_d = win_level;
		end
	end

	// no request and no active level after reset
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			active_q <= '0;
			ack_phase_q <= 1'b0;
			req_q <= 1'b0;
			num_q <= int_prio_pkg::NO_SOURCE;
			lvl_q <= 2'h0;
		end else begin
			active_q <= active_d;
			ack_phase_q <= ack_phase_d;
			req_q <= req_d;
			num_q <= num_d;
			lvl_q <= lvl_d;
		end
	end

	// ------------------------------------------------------------------
	// events and the status interrupt
	// ------------------------------------------------------------------
	// a read clears only the bits its answer carried, so a late event survives
	always_comb begin
		logic [3:0] still_active;
		still_active = active_q;
		if (returned) still_active[cur_level] = 1'b0;
		ev_d = ev_q;
		if (rd_hit && idx == int_prio_pkg::IDX_INT_STATUS) begin
			ev_d = ev_q & ~rdata_q[2:0];
		end
		if (taken) begin
			ev_d[int_prio_pkg::EV_TAKEN] = 1'b1;
			if (|still_active) ev_d[int_prio_pkg::EV_PREEMPT] = 1'b1;
		end
		if (returned) ev_d[int_prio_pkg::EV_RETURN] = 1'b1;
		irq_d = |(ev_d & mask_d);
	end

	// events cleared by reset
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ev_q <= int_prio_pkg::EV_RESET;
			irq_q <= 1'b0;
		end else begin
			ev_q <= ev_d;
			irq_q <= irq_d;
		end
	end

	// ------------------------------------------------------------------
	// outputs from flip-flops, waitrequest decoded from the bus state
	// ------------------------------------------------------------------
	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = (bus_q == BUS_IDLE); // low only in the answer cycle
	assign cpu_int_req_o = req_q;
	assign cpu_int_num_o = num_q;
	assign irq_o = irq_q;

endmodule

// ===== core/prio_select.sv
// combinational pick of the winning request by level and polling order
`timescale 1ns/1ps
module prio_select (
	// requests and group levels
	input wire logic [17:0] req_i,
	input wire logic [11:0] group_level_i,
	// result
	output logic valid_o,
	output logic [4:0] num_o,
	output logic [1:0] level_o
);

	// equal-level ties go to the earlier entry of this list
	localparam logic [4:0] POLL [18] = '{5'h00, 5'h10, 5'h08, 5'h01, 5'h09, 5'h02,
		5'h0a, 5'h03, 5'h0b, 5'h04, 5'h0c, 5'h05, 5'h0d, 5'h06, 5'h07, 5'h0e,
		5'h0f, 5'h11};

	// group of an interrupt number: 0..5 map to groups 0..5, 8..13 likewise,
	// 16 and 17 to groups 0 and 5, and 6,7,14,15 to groups 1..4
	function automatic logic [2:0] group_of(input logic [4:0] n);
		logic [2:0] g;
		g = 3'h0;
		unique case (n)
			5'h06: g = 3'h1;
			5'h07: g = 3'h2;
			5'h0e: g = 3'h3;
			5'h0f: g = 3'h4;
			5'h10: g = 3'h0;
			5'h11: g = 3'h5;
			default: g = (n >= 5'h08) ? 3'(n - 5'h08) : n[2:0];
		endcase
		return g;
	endfunction

	// scan in polling order, keep only a strictly higher level
	always_comb begin
		logic [4:0] n;
		logic [2:0] g;
		logic [1:0] lv;
		n = 5'h00;
		g = 3'h0;
		lv = 2'h0;
		valid_o = 1'b0;
		num_o = int_prio_pkg::NO_SOURCE;
		level_o = 2'h0;
		for (int i = 0; i < 18; i++) begin
			n = POLL[i];
			g = group_of(n);
			lv = group_level_i[2*g +: 2];
			if (req_i[n] && (!valid_o || lv > level_o)) begin
				valid_o = 1'b1;
				num_o = n;
				level_o = lv;
			end
		end
	end

endmodule

// ===== verif/cpu_model.sv
// cpu model: takes vectors after a set delay and returns from service
`timescale 1ns/1ps
module cpu_model (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// resolver side
	input wire logic int_req_i,
	output logic ack_o,
	output logic reti_o,
	// bench control
	input wire logic en_i,
	input wire logic auto_ret_i,
	input wire logic ret_i,
	input wire logic [1:0] slow_i
);
	logic [1:0] cnt_q;
	logic [2:0] rc_q;
	// ack after slow_i cycles, never again on the edge that drops the request
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= 2'h0;
			rc_q <= 3'h0;
			ack_o <= 1'b0;
			reti_o <= 1'b0;
		end else begin
			ack_o <= en_i && int_req_i && !ack_o && cnt_q == slow_i;
			cnt_q <= (en_i && int_req_i && !ack_o && cnt_q != slow_i) ? cnt_q + 2'h1 : 2'h0;
			rc_q <= (ack_o && auto_ret_i) ? 3'h4 : rc_q - 3'(rc_q != 3'h0);
			reti_o <= ret_i || rc_q == 3'h1;
		end
	end
endmodule

// ===== verif/interrupt_priority_resolver_bench.sv
// bench: register, polling order, nesting and status interrupt scenarios
`timescale 1ns/1ps
module interrupt_priority_resolver_bench;
	// ----------------
	// signals and tables
	// ----------------
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [9:0] avs_address_i = 10'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o, cpu_ack_i, cpu_reti_i, cpu_int_req_o, irq_o;
	logic [17:0] src_req_i = 18'h0;
	logic [4:0] cpu_int_num_o;
	logic en = 1'b0, aret = 1'b0, ret = 1'b0;
	logic [1:0] slow = 2'h0;
	logic [7:0] rq[$];
	logic [4:0] vq[$];
	int error_cnt = 0, n_tests = 0, cyc = 0;
	int poll[18] = '{0, 16, 8, 1, 9, 2, 10, 3, 11, 4, 12, 5, 13, 6, 7, 14, 15, 17};
	int grp[18] = '{0, 1, 2, 3, 4, 5, 1, 2, 0, 1, 2, 3, 4, 5, 3, 4, 0, 5};
	int fl[5] = '{6, 7, 14, 15, 17};

	always #2 clock_i = ~clock_i;

	interrupt_priority_resolver DUT (.clock_i(clock_i), .rstn_i(rstn_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.src_req_i(src_req_i), .cpu_ack_i(cpu_ack_i), .cpu_reti_i(cpu_reti_i),
		.cpu_int_req_o(cpu_int_req_o), .cpu_int_num_o(cpu_int_num_o), .irq_o(irq_o));
	cpu_model cpu (.clock_i(clock_i), .rstn_i(rstn_i), .int_req_i(cpu_int_req_o),
		.ack_o(cpu_ack_i), .reti_o(cpu_reti_i), .en_i(en), .auto_ret_i(aret), .ret_i(ret),
		.slow_i(slow));

	// ----------------
	// tasks
	// ----------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (error_cnt == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clock_i);
		avs_address_i <= {idx, 2'b00};
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_writedata_i <= {24'h0, d};
		do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		rq.push_back(exp);
		bus(1'b0, idx, 8'h00);
	endtask
	task automatic pulse(input logic [17:0] m);
		@(posedge clock_i);
		src_req_i <= m;
		@(posedge clock_i);
		src_req_i <= 18'h0;
	endtask
	task automatic rti;
		@(posedge clock_i);
		ret <= 1'b1;
		@(posedge clock_i);
		ret <= 1'b0;
	endtask
	task automatic drain;
		repeat (800) if (vq.size() != 0) @(posedge clock_i);
		repeat (10) @(posedge clock_i);
	endtask

	// watcher: oldest note against each read answer and each taken vector; hang limit
	always @(posedge clock_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0) check(avs_readdata_o[7:0], rq.pop_front());
		if (cpu_ack_i && cpu_int_req_o === 1'b1) check(cpu_int_num_o, vq.pop_front());
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			wrap_up();
		end
	end

	// ----------------
	// main sequence
	// ----------------
	initial begin
		logic [5:0] lo, hi;
		lo = 6'($urandom(32'hb1e30caa));
		repeat (16) @(posedge clock_i);
		rstn_i <= 1'b1;
		rd(8'ha9, 8'h00);
		rd(8'hb9, 8'h00);
		rd(8'he8, 8'h00);
		bus(1'b1, 8'h10, 8'hff);
		rd(8'h10, 8'h00);
		// low byte disabled: the write must not land
		avs_byteenable_i <= 4'he;
		bus(1'b1, 8'ha9, 8'h3f);
		avs_byteenable_i <= 4'hf;
		rd(8'ha9, 8'h00);
		// each source sets its own flag bit; software clears it
		for (int b = 0; b < 5; b++) begin
			pulse(18'h1 << fl[b]);
			rd(8'he8, 8'h01 << b);
			bus(1'b1, 8'he8, 8'h00);
		end
		rd(8'he8, 8'h00);
		bus(1'b1, 8'he8, 8'h10);
		rd(8'he8, 8'h10);
		vq.push_back(5'd17);
		en <= 1'b1;
		aret <= 1'b1;
		drain();
		rd(8'he8, 8'h00);
		// all sources at once, first at the lowest levels then under random ones: level first, then polling order
		for (int r = 0; r < 6; r++) begin
			lo = (r == 0) ? 6'h00 : 6'($urandom);
			hi = (r == 0) ? 6'h00 : 6'($urandom);
			slow <= 2'($urandom);
			bus(1'b1, 8'ha9, {2'b00, lo});
			bus(1'b1, 8'hb9, {2'b00, hi});
			rd(8'ha9, {2'b00, lo});
			rd(8'hb9, {2'b00, hi});
			for (int lv = 3; lv >= 0; lv--)
				foreach (poll[i]) if ({hi[grp[poll[i]]], lo[grp[poll[i]]]} == lv)
					vq.push_back(5'(poll[i]));
			pulse(18'h3ffff);
			drain();
		end
		// nesting: same level withheld, higher level preempts, withheld one follows
		aret <= 1'b0;
		bus(1'b1, 8'ha9, 8'h01);
		bus(1'b1, 8'hb9, 8'h00);
		vq.push_back(5'd1);
		pulse(18'h00002);
		repeat (8) @(posedge clock_i);
		pulse(18'h00200);
		repeat (6) @(posedge clock_i);
		check(cpu_int_req_o, 8'h00);
		vq.push_back(5'd0);
		pulse(18'h00001);
		repeat (8) @(posedge clock_i);
		rti();
		repeat (6) @(posedge clock_i);
		check(cpu_int_req_o, 8'h00);
		vq.push_back(5'd9);
		rti();
		drain();
		rti();
		// status interrupt: events, mask, clear on read
		rd(8'hf0, 8'h07);
		rd(8'hf0, 8'h00);
		bus(1'b1, 8'hf1, 8'h01);
		vq.push_back(5'd3);
		pulse(18'h00008);
		repeat (8) @(posedge clock_i);
		check(irq_o, 8'h01);
		bus(1'b1, 8'hf1, 8'h00);
		repeat (3) @(posedge clock_i);
		check(irq_o, 8'h00);
		bus(1'b1, 8'hf1, 8'h01);
		repeat (3) @(posedge clock_i);
		check(irq_o, 8'h01);
		rd(8'hf0, 8'h01);
		repeat (3) @(posedge clock_i);
		check(irq_o, 8'h00);
		rti();
		repeat (6) @(posedge clock_i);
		check(8'(vq.size() + rq.size()), 8'h00);
		wrap_up();
	end
endmodule

// ===== verif/interrupt_priority_resolver_props.sv
// checker: bus, vector and status interrupt properties at the resolver ports
`timescale 1ns/1ps
module interrupt_priority_resolver_props (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// avalon-mm slave
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// sources, cpu handshake, status interrupt
	input wire logic [17:0] src_req_i,
	input wire logic cpu_ack_i,
	input wire logic cpu_reti_i,
	input wire logic cpu_int_req_o,
	input wire logic [4:0] cpu_int_num_o,
	input wire logic irq_o
);
	default clocking dclk @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	logic [2:0] dep_q, dep_d, msk_q, msk_d;
	logic mapped;
	// nesting depth and mask shadow; a stray return is ignored so the depth never wraps
	always_comb begin
		dep_d = dep_q + 3'(cpu_ack_i && cpu_int_req_o) - 3'(cpu_reti_i && dep_q != 3'h0);
		msk_d = msk_q;
		if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
			&& avs_address_i[9:2] == 8'hf1) msk_d = avs_writedata_i[2:0];
	end
	// shadow registers
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dep_q <= 3'h0;
			msk_q <= 3'h0;
		end else begin
			dep_q <= dep_d;
			msk_q <= msk_d;
		end
	end
	// every decoded place of the map
	assign mapped = avs_address_i[9:2] inside {8'ha9, 8'hb9, 8'he8, [8'hf0:8'hf4]};
	a_wait_short: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("bus access not answered next cycle");
	a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && !mapped
		|-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
	a_idle_num: assert property (!cpu_int_req_o |-> cpu_int_num_o == 5'h1f)
		else $error("vector number not idle without request");
	a_num_range: assert property (cpu_int_req_o |-> cpu_int_num_o <= 5'd17)
		else $error("vector number outside the sources");
	a_ack_drops: assert property (cpu_ack_i && cpu_int_req_o |=> !cpu_int_req_o)
		else $error("request held after acknowledge");
	a_src_reaches: assert property (src_req_i[0] && dep_q == 3'h0 && !cpu_int_req_o
		##1 !cpu_ack_i |-> ##1 cpu_int_req_o) else $error("idle source not requested");
	a_mask_quiet: assert property ((msk_q == 3'h0) [*2] |-> !irq_o)
		else $error("status interrupt with all masked");
	c_preempt: cover property (cpu_ack_i && cpu_int_req_o && dep_q != 3'h0);
	c_irq: cover property ($rose(irq_o));
	c_unmapped: cover property (avs_read_i && !avs_waitrequest_o && !mapped);
endmodule

bind interrupt_priority_resolver interrupt_priority_resolver_props u_props (
	.clock_i(clock_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .src_req_i(src_req_i), .cpu_ack_i(cpu_ack_i),
	.cpu_reti_i(cpu_reti_i), .cpu_int_req_o(cpu_int_req_o), .cpu_int_num_o(cpu_int_num_o),
	.irq_o(irq_o));
